/* File: core/cce_executor.sv */
// Operation
// - Identification reply: maker, model code, serial, revision a.b.c, comma separated.
// - Operation-complete pulse only once all earlier held commands have run.
// - Operation-complete query queues ASCII 1 after all earlier commands.
// - While the trigger sequence runs, received commands other than reset wait in the queue.
// - Back at idle, waiting commands run in order, completion after last.
// - Reset command restores beeper and line-frequency defaults.
// - Reset command drops every waiting command.
// - Reset command cancels any owed completion bit or 1 still in the queue; a 1 already being sent finishes.
// - Self-test query runs the test and queues its code, 0 is pass.
// - Wait-to-continue is accepted and does nothing.
// - Beeper enable is writable and readable; immediate beep sounds.
// - Version query answers 1999.0.
// - Line frequency accepts only 50 or 60 and reads back.
// - Sensor query answers name, serial, cal text, type, subtype, flags.
// - Sensor flags are the sum of fixed weights 1,2,16,32,64,256.
// - Command termination returns the command path to root.
module cce_executor
  import cce_pkg::*;
#(
  parameter int          PEND_DEPTH          = 8,
  parameter int          BEEP_CYCLES         = BEEP_TIME_US * CLK_MHZ,
  // Identity values are arbitrary
  parameter logic [31:0] MFR_NAME            = 32'h564E_4452,
  parameter logic [31:0] MODEL_CODE_FIELD    = 32'h3030_3031,
  parameter logic [31:0] SERIAL_NUMBER_FIELD = 32'h3030_3030,
  parameter logic [3:0]  REV_MAJOR           = 4'h1,
  parameter logic [3:0]  REV_MINOR           = 4'h0,
  parameter logic [3:0]  REV_PATCH           = 4'h0
) (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_cmd_valid,
  input  wire cce_cmd_t    i_cmd,
  output logic             o_cmd_ready,
  input  wire logic        i_term,
  input  wire logic        i_meas_done,
  input  wire cce_sensor_t i_sensor,
  output logic             o_tst_start,
  input  wire logic        i_tst_done,
  input  wire logic [3:0]  i_tst_code,
  output logic             o_tx_valid,
  output logic [7:0]       o_tx_data,
  input  wire logic        i_tx_ready,
  output logic             o_opc_set,
  output logic             o_trig_active,
  output logic             o_beep,
  output logic             o_beep_en,
  output logic [7:0]       o_lfreq,
  output cce_path_t        o_path,
  output logic             o_defaults,
  output logic             o_cmd_error,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata
);

  // Depth must be a power of two so the pointers wrap by themselves
  localparam int               PTR_W    = $clog2(PEND_DEPTH);
  localparam int               CNT_W    = PTR_W + 1;
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(PEND_DEPTH);

  cce_state_t       st_ff;
  cce_cmd_t         pend_q [PEND_DEPTH];
  logic [PTR_W-1:0] wr_ptr_ff;
  logic [PTR_W-1:0] rd_ptr_ff;
  logic [CNT_W-1:0] count_ff;
  logic             trig_ff;
  logic             beep_en_ff;
  logic [7:0]       lfreq_ff;
  logic [31:0]      beep_cnt_ff;
  logic [LINE_W-1:0] line_ff;
  cce_path_t        path_ff;
  logic             opc_set_ff;
  logic             tst_start_ff;
  logic             defaults_ff;
  logic             err_ff;
  logic [31:0]      rdata_ff;
  logic             rst_cmd;
  logic             push;
  logic             pop;
  logic             tx_take;
  logic             tx_last;
  cce_cmd_t         exec;

  function automatic logic [7:0] digit(input logic [3:0] v);
    digit = CH_ZERO + ((v > 4'h9) ? 8'h09 : {4'h0, v});
  endfunction

  // Fixed three digits; leading zeros keep the reply length constant
  function automatic logic [23:0] dec3(input logic [9:0] v);
    logic [9:0] h;
    logic [9:0] t;
    logic [9:0] u;
    h = v / 10'd100;
    t = (v % 10'd100) / 10'd10;
    u = v % 10'd10;
    dec3 = {digit(h[3:0]), digit(t[3:0]), digit(u[3:0])};
  endfunction

  function automatic logic [9:0] flag_sum(input cce_sensor_t s);
    flag_sum = (s.pwr  ? FLG_POWER  : 10'h000)
             + (s.nrg  ? FLG_ENERGY : 10'h000)
             + (s.resp ? FLG_RESP   : 10'h000)
             + (s.wave ? FLG_WAVE   : 10'h000)
             + (s.tau  ? FLG_TAU    : 10'h000)
             + (s.temp ? FLG_TEMP   : 10'h000);
  endfunction

  function automatic logic lf_ok(input logic [7:0] v);
    lf_ok = (v == LFREQ_50) || (v == LFREQ_60);
  endfunction

  function automatic logic is_query(input cce_op_t op);
    is_query = (op == OP_IDN_Q) || (op == OP_OPC_Q) ||
               (op == OP_BEEP_Q) || (op == OP_VER_Q) ||
               (op == OP_LFREQ_Q) ||
               (op == OP_ATTACHED_SENSOR_INFO_QUERY);
  endfunction

  // Replies are left-justified; every one closes with a newline
  function automatic logic [LINE_W-1:0] build_line(
    input cce_op_t     op,
    input logic [3:0]  code,
    input logic        be,
    input logic [7:0]  lf,
    input cce_sensor_t s
  );
    logic [LINE_W-1:0] l;
    logic [23:0]       lfd;
    l = '0;
    lfd = dec3({2'b00, lf});
    case (op)
      OP_IDN_Q:
        l[LINE_W-1 -: IDN_LEN*8] = {MFR_NAME, CH_COMMA,
          MODEL_CODE_FIELD, CH_COMMA, SERIAL_NUMBER_FIELD, CH_COMMA,
          digit(REV_MAJOR), CH_DOT, digit(REV_MINOR), CH_DOT,
          digit(REV_PATCH), CH_LF};
      OP_OPC_Q:
        l[LINE_W-1 -: BIT_LEN*8] = {CH_ONE, CH_LF};
      OP_TST_Q:
        l[LINE_W-1 -: BIT_LEN*8] = {digit(code), CH_LF};
      OP_BEEP_Q:
        l[LINE_W-1 -: BIT_LEN*8] = {be ? CH_ONE : CH_ZERO, CH_LF};
      OP_VER_Q:
        l[LINE_W-1 -: VER_LEN*8] = {VER_TEXT, CH_LF};
      OP_LFREQ_Q:
        l[LINE_W-1 -: LFQ_LEN*8] = {lfd[15:0], CH_LF};
      OP_ATTACHED_SENSOR_INFO_QUERY:
        l[LINE_W-1 -: SNS_LEN*8] = {CH_QUOTE, s.name, CH_QUOTE,
          CH_COMMA, CH_QUOTE, s.serial, CH_QUOTE, CH_COMMA,
          CH_QUOTE, s.cal, CH_QUOTE, CH_COMMA,
          dec3({2'b00, s.kind}), CH_COMMA,
          dec3({2'b00, s.subkind}), CH_COMMA,
          dec3(flag_sum(s)), CH_LF};
      default: l = '0;
    endcase
    build_line = l;
  endfunction

  assign rst_cmd = i_cmd_valid && (i_cmd.op == OP_RST);
  assign o_cmd_ready = (count_ff != CNT_FULL) || (i_cmd.op == OP_RST);
  assign push = i_cmd_valid && (i_cmd.op != OP_RST)
             && (count_ff != CNT_FULL);
  // Nothing leaves the queue while the trigger sequence runs
  assign pop = (st_ff == ST_IDLE) && !trig_ff && (count_ff != '0)
            && !rst_cmd;
  assign exec = pend_q[rd_ptr_ff];
  assign tx_take = (st_ff == ST_RESP) && i_tx_ready;
  assign tx_last = line_ff[LINE_W-1 -: 8] == CH_LF;

  // Commands keep their arrival order, so completion follows all before
  always_ff @(posedge i_clk) begin
    if (push) begin
      pend_q[wr_ptr_ff] <= i_cmd;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else if (rst_cmd) begin
      rd_ptr_ff <= wr_ptr_ff;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + PTR_W'(1);
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + PTR_W'(1);
      end
      count_ff <= count_ff + CNT_W'(push) - CNT_W'(pop);
    end
  end

  // A reply already being sent finishes so the host never sees half a line
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_ff   <= ST_IDLE;
      line_ff <= '0;
    end else begin
      unique case (st_ff)
        ST_IDLE: begin
          if (pop && (exec.op == OP_TST_Q)) begin
            st_ff <= ST_TEST;
          end else if (pop && is_query(exec.op)) begin
            line_ff <= build_line(exec.op, 4'h0, beep_en_ff,
                                  lfreq_ff, i_sensor);
            st_ff   <= ST_RESP;
          end
        end
        ST_TEST: begin
          if (i_tst_done) begin
            line_ff <= build_line(OP_TST_Q, i_tst_code, beep_en_ff,
                                  lfreq_ff, i_sensor);
            st_ff   <= ST_RESP;
          end
        end
        ST_RESP: begin
          if (tx_take) begin
            line_ff <= line_ff << 8;
            if (tx_last) begin
              st_ff <= ST_IDLE;
            end
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      opc_set_ff   <= 1'b0;
      tst_start_ff <= 1'b0;
      defaults_ff  <= 1'b0;
      err_ff       <= 1'b0;
    end else begin
      opc_set_ff   <= pop && (exec.op == OP_OPC);
      tst_start_ff <= pop && (exec.op == OP_TST_Q);
      defaults_ff  <= rst_cmd;
      err_ff       <= (i_cmd_valid && !o_cmd_ready) ||
                      (pop && (exec.op == OP_LFREQ_SET) &&
                       !lf_ok(exec.arg));
    end
  end

  // Start of a trigger sequence wins over its end in the same cycle
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      trig_ff <= 1'b0;
    end else if (rst_cmd) begin
      trig_ff <= 1'b0;
    end else if (pop && (exec.op == OP_INIT)) begin
      trig_ff <= 1'b1;
    end else if (i_meas_done) begin
      trig_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      beep_en_ff <= BEEP_DEF;
    end else if (rst_cmd) begin
      beep_en_ff <= BEEP_DEF;
    end else if (pop && (exec.op == OP_BEEP_SET)) begin
      beep_en_ff <= (exec.arg != 8'h00);
    end else if (i_wr && (i_addr == REG_CTRL)) begin
      beep_en_ff <= i_wdata[CTRL_BEEP_BIT];
    end
  end

  // Out-of-range frequencies leave the stored value untouched
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      lfreq_ff <= LFREQ_DEF;
    end else if (rst_cmd) begin
      lfreq_ff <= LFREQ_DEF;
    end else if (pop && (exec.op == OP_LFREQ_SET)) begin
      if (lf_ok(exec.arg)) begin
        lfreq_ff <= exec.arg;
      end
    end else if (i_wr && (i_addr == REG_LFREQ)) begin
      if (lf_ok(i_wdata[7:0])) begin
        lfreq_ff <= i_wdata[7:0];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      beep_cnt_ff <= '0;
    end else if (rst_cmd) begin
      beep_cnt_ff <= '0;
    end else if (pop && (exec.op == OP_BEEP_IMM) && beep_en_ff) begin
      beep_cnt_ff <= 32'(BEEP_CYCLES);
    end else if (beep_cnt_ff != '0) begin
      beep_cnt_ff <= beep_cnt_ff - 32'h0000_0001;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      path_ff <= PATH_ROOT;
    end else if (i_term) begin
      path_ff <= PATH_ROOT;
    end else if (push) begin
      if (i_cmd.op == OP_ATTACHED_SENSOR_INFO_QUERY) begin
        path_ff <= PATH_SENS;
      end else if (i_cmd.op >= OP_BEEP_IMM && i_cmd.op <= OP_LFREQ_Q) begin
        path_ff <= PATH_SYST;
      end
    end
  end

  // Read data stands for exactly one cycle; unmapped reads give zero
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= '0;
      if (i_rd) begin
        case (i_addr)
          REG_CTRL:   rdata_ff[CTRL_BEEP_BIT] <= beep_en_ff;
          REG_LFREQ:  rdata_ff[7:0] <= lfreq_ff;
          REG_STATUS: begin
            rdata_ff[STAT_CNT_LSB +: CNT_W] <= count_ff;
            rdata_ff[STAT_ST_LSB +: 3]      <= st_ff;
            rdata_ff[STAT_TRIG_BIT]         <= trig_ff;
          end
          default: rdata_ff <= '0;
        endcase
      end
    end
  end

  assign o_tx_valid    = (st_ff == ST_RESP);
  assign o_tx_data     = line_ff[LINE_W-1 -: 8];
  assign o_opc_set     = opc_set_ff;
  assign o_tst_start   = tst_start_ff;
  assign o_trig_active = trig_ff;
  assign o_beep        = (beep_cnt_ff != '0);
  assign o_beep_en     = beep_en_ff;
  assign o_lfreq       = lfreq_ff;
  assign o_path        = path_ff;
  assign o_defaults    = defaults_ff;
  assign o_cmd_error   = err_ff;
  assign o_rdata       = rdata_ff;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  AST_IDN_FIRST_BYTE: assert property (
    pop && exec.op == OP_IDN_Q |=> o_tx_valid && o_tx_data == MFR_NAME[31:24])
    else $error("identification reply does not start with maker");

  AST_OPC_ONLY_AT_IDLE: assert property (
    o_opc_set |-> $past(st_ff) == ST_IDLE && !$past(trig_ff))
    else $error("completion bit set while work was outstanding");

  AST_OPCQ_ONE: assert property (
    pop && exec.op == OP_OPC_Q |=> o_tx_valid && o_tx_data == CH_ONE)
    else $error("completion query reply is not a 1");

  AST_HOLD_WHILE_TRIG: assert property (
    trig_ff && !rst_cmd |=> count_ff >= $past(count_ff))
    else $error("a command ran during the trigger sequence");

  AST_RST_DEFAULTS: assert property (
    rst_cmd |=> beep_en_ff == BEEP_DEF && lfreq_ff == LFREQ_DEF
            && o_defaults)
    else $error("reset command did not restore defaults");

  AST_RST_FLUSH: assert property (
    rst_cmd |=> count_ff == '0 && !trig_ff)
    else $error("reset command left commands waiting");

  AST_RST_CANCEL: assert property (
    rst_cmd |=> !o_opc_set [*2])
    else $error("completion still produced after reset command");

  AST_WAI_NOP: assert property (
    pop && exec.op == OP_WAI |=> st_ff == ST_IDLE && !o_tx_valid)
    else $error("wait command had an effect");

  AST_BEEP: assert property (
    pop && exec.op == OP_BEEP_IMM && beep_en_ff && !rst_cmd |=> o_beep)
    else $error("immediate beep did not sound");

  AST_LFREQ_RANGE: assert property (
    lfreq_ff == LFREQ_50 || lfreq_ff == LFREQ_60)
    else $error("line frequency outside 50 or 60");

  AST_PATH_ROOT: assert property (
    i_term |=> o_path == PATH_ROOT)
    else $error("termination did not return path to root");

  AST_NEWLINE_END: assert property (
    tx_take && tx_last |=> st_ff == ST_IDLE && !o_tx_valid)
    else $error("reply did not end at the newline");

endmodule

/* File: inc/cce_pkg.sv */
package cce_pkg;

  localparam int LINE_BYTES   = 36;
  localparam int LINE_W       = LINE_BYTES * 8;
  localparam int IDN_LEN      = 21;
  localparam int SNS_LEN      = 33;
  localparam int VER_LEN      = 7;
  localparam int LFQ_LEN      = 3;
  localparam int BIT_LEN      = 2;
  localparam int CLK_MHZ      = 100;
  localparam int BEEP_TIME_US = 100;

  localparam logic [7:0]  CH_LF    = 8'h0A;
  localparam logic [7:0]  CH_QUOTE = 8'h22;
  localparam logic [7:0]  CH_COMMA = 8'h2C;
  localparam logic [7:0]  CH_DOT   = 8'h2E;
  localparam logic [7:0]  CH_ZERO  = 8'h30;
  localparam logic [7:0]  CH_ONE   = 8'h31;
  localparam logic [47:0] VER_TEXT = 48'h3139_3939_2E30;

  localparam logic [7:0] LFREQ_50  = 8'h32;
  localparam logic [7:0] LFREQ_60  = 8'h3C;
  localparam logic [7:0] LFREQ_DEF = LFREQ_50;
  localparam logic       BEEP_DEF  = 1'b1;

  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_LFREQ     = 8'h04;
  localparam logic [7:0] REG_STATUS    = 8'h08;
  localparam int         CTRL_BEEP_BIT = 0;
  localparam int         STAT_CNT_LSB  = 0;
  localparam int         STAT_ST_LSB   = 8;
  localparam int         STAT_TRIG_BIT = 16;

  localparam logic [9:0] FLG_POWER  = 10'h001;
  localparam logic [9:0] FLG_ENERGY = 10'h002;
  localparam logic [9:0] FLG_RESP   = 10'h010;
  localparam logic [9:0] FLG_WAVE   = 10'h020;
  localparam logic [9:0] FLG_TAU    = 10'h040;
  localparam logic [9:0] FLG_TEMP   = 10'h100;

  typedef enum logic [3:0] {
    OP_IDN_Q    = 4'h0, OP_OPC     = 4'h1, OP_OPC_Q   = 4'h2,
    OP_RST      = 4'h3, OP_TST_Q   = 4'h4, OP_WAI     = 4'h5,
    OP_BEEP_IMM = 4'h6, OP_BEEP_SET = 4'h7, OP_BEEP_Q = 4'h8,
    OP_VER_Q    = 4'h9, OP_LFREQ_SET = 4'hA, OP_LFREQ_Q = 4'hB,
    OP_ATTACHED_SENSOR_INFO_QUERY = 4'hC, OP_INIT = 4'hD
  } cce_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, ST_TEST = 3'b010, ST_RESP = 3'b100
  } cce_state_t;

  typedef enum logic [1:0] {
    PATH_ROOT = 2'h0, PATH_SYST = 2'h1, PATH_SENS = 2'h2
  } cce_path_t;

  typedef struct packed {
    cce_op_t    op;
    logic [7:0] arg;
  } cce_cmd_t;

  typedef struct packed {
    logic [31:0] name;
    logic [31:0] serial;
    logic [31:0] cal;
    logic [7:0]  kind;
    logic [7:0]  subkind;
    logic        pwr;
    logic        nrg;
    logic        resp;
    logic        wave;
    logic        tau;
    logic        temp;
  } cce_sensor_t;

endpackage

/* File: test/cce_host_model.sv */
module cce_host_model (
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_slow,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  output logic            o_tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] rx[$];

  // Slow mode takes a byte every other cycle so replies are stalled
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_tx_ready <= 1'b0;
    end else begin
      o_tx_ready <= i_slow ? ~o_tx_ready : 1'b1;
    end
  end

  // Bytes kept in arrival order, newline included
  always @(posedge i_clk) begin
    if (i_tx_valid === 1'b1 && o_tx_ready === 1'b1) begin
      rx.push_back(i_tx_data);
    end
  end
endmodule

/* File: test/tb.sv */
module tb import cce_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic        i_clk, i_resetn, i_cmd_valid, i_term, i_meas_done;
  cce_cmd_t    i_cmd;
  cce_sensor_t i_sensor;
  logic        i_tst_done, i_tx_ready, i_wr, i_rd, slow;
  logic [3:0]  i_tst_code;
  logic [7:0]  i_addr, o_tx_data, o_lfreq;
  logic [31:0] i_wdata, o_rdata, d;
  logic        o_cmd_ready, o_tst_start, o_tx_valid, o_opc_set;
  logic        o_trig_active, o_beep, o_beep_en, o_defaults, o_cmd_error;
  cce_path_t   o_path;
  int          error_cnt, n_tests, opc_n, err_n, beep_n, dflt_n, b;

  cce_executor #(.BEEP_CYCLES(4)) dut_u (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_cmd_valid(i_cmd_valid),
    .i_cmd(i_cmd), .o_cmd_ready(o_cmd_ready), .i_term(i_term),
    .i_meas_done(i_meas_done), .i_sensor(i_sensor),
    .o_tst_start(o_tst_start), .i_tst_done(i_tst_done),
    .i_tst_code(i_tst_code), .o_tx_valid(o_tx_valid),
    .o_tx_data(o_tx_data), .i_tx_ready(i_tx_ready), .o_opc_set(o_opc_set),
    .o_trig_active(o_trig_active), .o_beep(o_beep), .o_beep_en(o_beep_en),
    .o_lfreq(o_lfreq), .o_path(o_path), .o_defaults(o_defaults),
    .o_cmd_error(o_cmd_error), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));

  cce_host_model host_u (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_slow(slow),
    .i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data),
    .o_tx_ready(i_tx_ready));

  always #5 i_clk = ~i_clk;

  always @(posedge i_clk) begin
    opc_n  += (o_opc_set === 1'b1);
    err_n  += (o_cmd_error === 1'b1);
    beep_n += (o_beep === 1'b1);
    dflt_n += (o_defaults === 1'b1);
  end

  task automatic tally_and_finish();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic send(input cce_op_t op, input logic [7:0] arg);
    @(posedge i_clk);
    i_cmd_valid <= 1'b1;
    i_cmd       <= '{op, arg};
    @(posedge i_clk);
    i_cmd_valid <= 1'b0;
  endtask

  task automatic reply(input string nm, input string s);
    int k = 0;
    while (host_u.rx.size() < s.len() && k < 400) begin
      @(negedge i_clk);
      k++;
    end
    repeat (6) @(negedge i_clk);
    chk({nm, " len"}, s.len(), host_u.rx.size());
    for (int i = 0; i < s.len() && i < host_u.rx.size(); i++) begin
      chk(nm, s[i], host_u.rx[i]);
    end
    host_u.rx.delete();
  endtask

  // Each reply is read whole before the next query goes out
  task automatic q(input cce_op_t op, input logic [7:0] a, input string s);
    send(op, a);
    reply(op.name(), s);
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    d = o_rdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic t_regs();
    rd(REG_CTRL);
    chk("ctrl rst", 32'h1, d);
    rd(REG_LFREQ);
    chk("lfreq rst", 32'h32, d);
    rd(8'h0C);
    chk("unmapped", 32'h0, d);
    wr(8'h0C, 32'hFF);
    wr(REG_CTRL, 32'h0);
    rd(REG_CTRL);
    chk("ctrl wr", 32'h0, d);
    chk("beep_en", 32'h0, o_beep_en);
    wr(REG_LFREQ, 32'h33);
    rd(REG_LFREQ);
    chk("lfreq bad wr", 32'h32, d);
    wr(REG_LFREQ, 32'h3C);
    rd(REG_LFREQ);
    chk("lfreq wr", 32'h3C, d);
    wr(REG_CTRL, 32'h1);
  endtask

  task automatic t_queries();
    q(OP_IDN_Q, 8'h00, "VNDR,0001,0000,1.0.0\n");
    q(OP_WAI, 8'h00, "");
    q(OP_OPC_Q, 8'h00, "1\n");
    q(OP_VER_Q, 8'h00, "1999.0\n");
    q(OP_LFREQ_Q, 8'h00, "60\n");
    b = err_n;
    send(OP_LFREQ_SET, 8'h37);
    repeat (4) @(posedge i_clk);
    chk("bad lfreq err", b + 1, err_n);
    q(OP_LFREQ_Q, 8'h00, "60\n");
    send(OP_LFREQ_SET, 8'h32);
    q(OP_LFREQ_Q, 8'h00, "50\n");
  endtask

  task automatic t_beep();
    send(OP_BEEP_SET, 8'h00);
    q(OP_BEEP_Q, 8'h00, "0\n");
    b = beep_n;
    send(OP_BEEP_IMM, 8'h00);
    repeat (20) @(posedge i_clk);
    chk("beep off", b, beep_n);
    send(OP_BEEP_SET, 8'h01);
    q(OP_BEEP_Q, 8'h00, "1\n");
    b = beep_n;
    send(OP_BEEP_IMM, 8'h00);
    repeat (20) @(posedge i_clk);
    chk("beep len", b + 4, beep_n);
  endtask

  task automatic t_test(input logic [3:0] code, input string s);
    int k = 0;
    send(OP_TST_Q, 8'h00);
    while (o_tst_start !== 1'b1 && k < 50) begin
      @(negedge i_clk);
      k++;
    end
    chk("tst start", 1'b1, o_tst_start);
    repeat (3) @(posedge i_clk);
    i_tst_done <= 1'b1;
    i_tst_code <= code;
    @(posedge i_clk);
    i_tst_done <= 1'b0;
    reply("tst", s);
  endtask

  task automatic t_trig();
    b = opc_n;
    send(OP_INIT, 8'h00);
    send(OP_OPC, 8'h00);
    send(OP_OPC_Q, 8'h00);
    repeat (30) @(negedge i_clk);
    chk("trig", 1'b1, o_trig_active);
    chk("held opc", b, opc_n);
    chk("held opc_q", 0, host_u.rx.size());
    @(posedge i_clk);
    i_meas_done <= 1'b1;
    @(posedge i_clk);
    i_meas_done <= 1'b0;
    reply("opc after idle", "1\n");
    chk("opc bit", b + 1, opc_n);
  endtask

  task automatic t_rst();
    send(OP_LFREQ_SET, 8'h3C);
    send(OP_BEEP_SET, 8'h00);
    b = opc_n;
    send(OP_INIT, 8'h00);
    send(OP_OPC, 8'h00);
    send(OP_OPC_Q, 8'h00);
    send(OP_RST, 8'h00);
    repeat (3) @(negedge i_clk);
    chk("defaults", 1, dflt_n);
    chk("rst trig", 1'b0, o_trig_active);
    @(posedge i_clk);
    i_meas_done <= 1'b1;
    @(posedge i_clk);
    i_meas_done <= 1'b0;
    repeat (30) @(negedge i_clk);
    chk("rst opc", b, opc_n);
    reply("rst opc_q", "");
    chk("rst lfreq", 8'h32, o_lfreq);
    chk("rst beep_en", 1'b1, o_beep_en);
  endtask

  task automatic t_sensor();
    q(OP_ATTACHED_SENSOR_INFO_QUERY, 8'h00,
      "\"SNSA\",\"1234\",\"CALX\",003,012,273\n");
    @(posedge i_clk);
    i_term <= 1'b1;
    @(posedge i_clk);
    i_term <= 1'b0;
    @(negedge i_clk);
    chk("path root", PATH_ROOT, o_path);
  endtask

  initial begin
    // Watchdog well above the few hundred cycles the tests need
    #200000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    {i_clk, i_resetn, i_cmd_valid, i_term, i_meas_done} = '0;
    {i_tst_done, i_wr, i_rd, slow, i_tst_code, i_addr, i_wdata} = '0;
    i_cmd    = '{OP_WAI, 8'h00};
    i_sensor = '{32'h534E_5341, 32'h3132_3334, 32'h4341_4C58, 8'h03,
                 8'h0C, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    repeat (5) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    t_regs();
    t_queries();
    t_beep();
    slow <= 1'b1;
    t_test(4'h0, "0\n");
    t_test(4'h3, "3\n");
    t_trig();
    slow <= 1'b0;
    t_rst();
    t_sensor();
    tally_and_finish();
  end
endmodule
